// >>> pkg/boot_aux_defines.vh
// constants for the boot and auxiliary register command block
`ifndef BOOT_AUX_DEFINES_VH
`define BOOT_AUX_DEFINES_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_CORR_STATUS_RD 8'h18
`define OP_BOOT_CFG_RD    8'h14
`define OP_BOOT_CFG_WR    8'h15
`define OP_NV_LEARN_PROG  8'h43
`define OP_VOL_LEARN_WR   8'h4a
`define OP_LEARN_PAT_RD   8'h41
`define OP_WRITE_ENABLE   8'h06
// ----------------------------------------
// boot_stream_config fields
// ----------------------------------------
`define BOOT_ADDR_MSB     31
`define BOOT_ADDR_LSB     9
`define BOOT_DELAY_MSB    8
`define BOOT_DELAY_LSB    1
`define BOOT_ENABLE_BIT   0
`define BOOT_CFG_RESET    32'h00000000
// ----------------------------------------
// status and config bit positions
// ----------------------------------------
`define SR1_WIP_BIT       0
`define SR1_WEL_BIT       1
`define SR1_EERR_BIT      5
`define SR1_PERR_BIT      6
`define CR1_QUAD_BIT      1
`define NV_LEARN_RESET    8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     50
`define NV_UPDATE_NS      500000
`define NV_UPDATE_CYC     (`NV_UPDATE_NS / `CLK_PERIOD_NS)
`define CORR_UNIT_BYTES   16
`endif

// >>> verif/boot_aux_properties.sv
// port assertions for the boot and auxiliary command block
`timescale 1ns/1ps
module boot_aux_properties #(
  parameter NV_CYC = 20
) (
  input wire        mclk,
  input wire        resetn,
  input wire        cs_n,
  input wire [3:0]  io_oe,
  input wire [31:0] corr_unit_addr,
  input wire [7:0]  status_register_1,
  input wire [31:0] boot_stream_config,
  input wire [7:0]  vol_learning_register
);
  logic [15:0] busy_cnt;
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 16'h0000;
    end else if (status_register_1[0]) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  oe_release_a: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("outputs driven while deselected");
  unit_align_a: assert property (corr_unit_addr[3:0] == 4'h0)
    else $error("unit address not aligned");
  cfg_guard_a: assert property ($changed(boot_stream_config)
    |-> $past(status_register_1[1])) else $error("config without latch");
  vol_guard_a: assert property ($changed(vol_learning_register)
    && $past(resetn, 2) |-> $past(status_register_1[1]))
    else $error("pattern without latch");
  busy_latch_a: assert property (status_register_1[0]
    |-> status_register_1[1]) else $error("busy without latch");
  end_latch_a: assert property ($fell(status_register_1[0])
    |-> ##[0:1] !status_register_1[1]) else $error("latch kept");
  busy_len_a: assert property ($fell(status_register_1[0])
    |-> busy_cnt >= NV_CYC - 2 && busy_cnt <= NV_CYC + 2)
    else $error("busy length wrong");
  err_sticky_a: assert property ($past(status_register_1[6])
    |-> status_register_1[6]) else $error("error flag lost");
endmodule
bind boot_aux_cmd boot_aux_properties #(.NV_CYC(NV_CYC)) props (
  .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .io_oe(io_oe),
  .corr_unit_addr(corr_unit_addr), .status_register_1(status_register_1),
  .boot_stream_config(boot_stream_config),
  .vol_learning_register(vol_learning_register));

// >>> verif/spi_host_model.sv
// host side serial controller model for the command pins
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] io_out,
  output logic            cs_n,
  output logic            sck,
  output logic            si
);
  logic quad_mode = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // ----------------------------------------
  // one framed command, mode 0
  // ----------------------------------------
  task automatic frame(input logic [63:0] tx, input int n, input int nr,
                       output logic [63:0] rx);
    rx = '0;
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < n + nr; i++) begin
      si <= (i < n) ? tx[n-1-i] : ~si;
      repeat (4) @(posedge mclk);
      // sck period of 8 mclk, well under limit
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      if (i >= n)
        rx = quad_mode ? {rx[59:0], io_out} : {rx[62:0], io_out[1]};
      sck <= 1'b0;
    end
    @(posedge mclk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the boot and auxiliary command block
`timescale 1ns/1ps
`include "boot_aux_defines.vh"
module testbench;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        erase_fail = 1'b0;
  logic        program_fail = 1'b0;
  logic [7:0]  quad_cfg = 8'h00;
  logic        cs_n, sck, si;
  logic [3:0]  io_out, io_oe;
  logic [31:0] corr_unit_addr, array_addr, boot_stream_config;
  logic [7:0]  status_register_1, vol_learning_register;
  logic [63:0] rx;
  int          fails = 0;
  int          tests_run = 0;
  always #25 mclk = ~mclk;
  spi_host_model host (.mclk(mclk), .io_out(io_out), .cs_n(cs_n),
    .sck(sck), .si(si));
  boot_aux_cmd #(.NV_CYC(20)) dut (.mclk(mclk), .resetn(resetn),
    .cs_n(cs_n), .sck(sck), .si(si), .io_out(io_out), .io_oe(io_oe),
    .volatile_config_2(4'h0), .config_register_1(quad_cfg),
    .ddr_learn_enable(1'b0),
    .correction_unit_status({corr_unit_addr[7:4], 4'h9}),
    .corr_unit_addr(corr_unit_addr), .array_data(array_addr[7:0]),
    .array_valid(1'b1), .array_ready(), .array_addr(array_addr),
    .erase_fail(erase_fail), .program_fail(program_fail),
    .status_register_1(status_register_1),
    .boot_stream_config(boot_stream_config),
    .vol_learning_register(vol_learning_register));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lsb_first(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status_register_1[0] !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n == 200) begin
      fails++;
      close_out();
    end
  endtask
  task automatic write_enable_cmd();
    host.frame({56'h0, `OP_WRITE_ENABLE}, 8, 0, rx);
    check("latch set", status_register_1[1], 1'b1);
  endtask
  task automatic pulse_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("status reset", status_register_1, 8'h00);
    check("config reset", boot_stream_config, `BOOT_CFG_RESET);
    check("pattern reset", vol_learning_register, `NV_LEARN_RESET);
    $display("test reset done");
  endtask
  task automatic t_guard();
    host.frame({24'h0, `OP_BOOT_CFG_WR, 32'hfeffffff}, 40, 0, rx);
    check("config guarded", boot_stream_config, 32'h0);
    host.frame({48'h0, `OP_VOL_LEARN_WR, 8'h77}, 16, 0, rx);
    check("pattern guarded", vol_learning_register, 8'h00);
    $display("test guard done");
  endtask
  task automatic t_cfg();
    write_enable_cmd();
    host.frame({24'h0, `OP_BOOT_CFG_WR, lsb_first(32'h12345678)}, 40, 0, rx);
    check("busy", status_register_1[0], 1'b1);
    wait_idle();
    check("config", boot_stream_config, 32'h12345678);
    check("latch clear", status_register_1[1], 1'b0);
    write_enable_cmd();
    host.frame({25'h0, `OP_BOOT_CFG_WR, 31'h0f0f0f0f}, 39, 0, rx);
    check("short write", boot_stream_config, 32'h12345678);
    check("short busy", status_register_1[0], 1'b0);
    host.frame({56'h0, `OP_BOOT_CFG_RD}, 8, 64, rx);
    check("config read", rx, {2{lsb_first(32'h12345678)}});
    $display("test config done");
  endtask
  task automatic t_learn();
    write_enable_cmd();
    host.frame({48'h0, `OP_VOL_LEARN_WR, 8'ha5}, 16, 0, rx);
    check("pattern write", vol_learning_register, 8'ha5);
    host.frame({56'h0, `OP_LEARN_PAT_RD}, 8, 16, rx);
    check("pattern read", rx, 64'ha5a5);
    $display("test learn done");
  endtask
  task automatic t_corr();
    host.frame({24'h0, `OP_CORR_STATUS_RD, 32'h1230}, 40, 136, rx);
    check("unit status", rx, {{7{8'h39}}, 8'h49});
    $display("test correction done");
  endtask
  task automatic t_fail();
    erase_fail <= 1'b1;
    write_enable_cmd();
    host.frame({24'h0, `OP_BOOT_CFG_WR, 32'h0}, 40, 0, rx);
    wait_idle();
    check("erase error", status_register_1[5], 1'b1);
    erase_fail   <= 1'b0;
    program_fail <= 1'b1;
    write_enable_cmd();
    host.frame({48'h0, `OP_NV_LEARN_PROG, 8'h3c}, 16, 0, rx);
    check("prog busy", status_register_1[0], 1'b1);
    wait_idle();
    check("prog error", status_register_1[6], 1'b1);
    check("prog latch", status_register_1[1], 1'b0);
    program_fail <= 1'b0;
    $display("test failure done");
  endtask
  task automatic t_boot();
    write_enable_cmd();
    host.frame({48'h0, `OP_NV_LEARN_PROG, 8'h5a}, 16, 0, rx);
    wait_idle();
    write_enable_cmd();
    host.frame({24'h0, `OP_BOOT_CFG_WR, lsb_first(32'h00000605)}, 40, 0, rx);
    wait_idle();
    check("boot config", boot_stream_config, 32'h00000605);
    pulse_reset();
    check("pattern restore", vol_learning_register, 8'h5a);
    host.frame(64'h0, 0, 27, rx);
    check("boot serial", rx[23:0], 24'h000102);
    host.frame({56'h0, `OP_LEARN_PAT_RD}, 8, 8, rx);
    check("command after boot", rx[7:0], 8'h5a);
    quad_cfg[`CR1_QUAD_BIT] <= 1'b1;
    pulse_reset();
    host.quad_mode = 1'b1;
    host.frame(64'h0, 0, 9, rx);
    host.quad_mode = 1'b0;
    check("boot quad", rx[23:0], 24'h000102);
    quad_cfg[`CR1_QUAD_BIT] <= 1'b0;
    $display("test boot done");
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    t_guard();
    t_cfg();
    t_learn();
    t_corr();
    t_fail();
    t_boot();
    close_out();
  end
endmodule

// >>> verilog/boot_aux_cmd.v
// serial flash command logic for boot stream and auxiliary registers
// Functional notes
// - after latency, status byte sent 16 times
// - chip select low advances to next unit
// - boot read armed after every reset
// - boot data withheld for delay count
// - boot starts at 512-byte aligned address
// - stream increments; chip select high ends it once a byte is sent
// - no second boot stream until reset
// - quad enable sends four bits per cycle in the boot stream only; 14h, 41h and 18h reads stay one bit per cycle
// - 14h reads config, low byte first
// - config read repeats every 32 cycles
// - 15h accepted only with latch set
// - write runs only after exact 32 bits
// - busy flag during update, clears latch
// - erase or program failure sets error flags
// - 43h takes one byte, needs latch
// - program busy, error flag, clears latch
// - 4ah writes volatile byte immediately
// - 41h repeats pattern every eight clocks
// - 06h sets the write enable latch
// - ddr latency drives pattern bits 7,5,3,1 over last four cycles
`timescale 1ns/1ps
`include "boot_aux_defines.vh"
module boot_aux_cmd #(
  parameter NV_CYC = `NV_UPDATE_CYC
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe,
  input  wire [3:0]  volatile_config_2,
  input  wire [7:0]  config_register_1,
  input  wire        ddr_learn_enable,
  input  wire [7:0]  correction_unit_status,
  output wire [31:0] corr_unit_addr,
  input  wire [7:0]  array_data,
  input  wire        array_valid,
  output wire        array_ready,
  output wire [31:0] array_addr,
  input  wire        erase_fail,
  input  wire        program_fail,
  output wire [7:0]  status_register_1,
  output wire [31:0] boot_stream_config,
  output wire [7:0]  vol_learning_register
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_CMD   = 3'd0;
  localparam S_ADDR  = 3'd1;
  localparam S_WAIT  = 3'd2;
  localparam S_OUT   = 3'd3;
  localparam S_DATA  = 3'd4;
  localparam S_BOOT  = 3'd5;
  localparam S_IDLE  = 3'd6;
  // ----------------------------------------
  // pin sampling, three stages
  // ----------------------------------------
  reg [2:0] cs_s_r;
  reg [2:0] sck_s_r;
  reg [2:0] si_s_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cs_s_r  <= 3'b111;
      sck_s_r <= 3'b000;
      si_s_r  <= 3'b000;
    end else begin
      cs_s_r  <= {cs_s_r[1:0], cs_n};
      sck_s_r <= {sck_s_r[1:0], sck};
      si_s_r  <= {si_s_r[1:0], si};
    end
  end
  wire cs_lo   = ~cs_s_r[1] & ~cs_s_r[2];
  wire cs_rise = cs_s_r[1] & cs_s_r[2];
  wire sck_up  = sck_s_r[1] & ~sck_s_r[2];
  wire sck_dn  = ~sck_s_r[1] & sck_s_r[2];
  wire sck_up_l = sck_up & cs_lo;
  wire sck_dn_l = sck_dn & cs_lo;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [2:0]  st_r;
  reg  [7:0]  op_r;
  reg  [5:0]  bit_r;
  reg  [31:0] sh_r;
  reg  [31:0] cfg_r = `BOOT_CFG_RESET;
  reg  [7:0]  nv_r  = `NV_LEARN_RESET;
  reg  [7:0]  vol_r;
  reg         wel_r;
  reg         wip_r;
  reg         eerr_r;
  reg         perr_r;
  reg         boot_arm_r;
  reg         busy_cfg_r;
  reg  [31:0] busy_cnt_r;
  reg  [31:0] addr_r;
  reg  [7:0]  lat_r;
  reg  [3:0]  rep_r;
  reg         held_r;
  reg         seen_r;
  reg  [7:0]  obyte_r;
  reg  [2:0]  obit_r;
  reg         reload_r;
  reg  [31:0] fetch_r;
  wire        quad = config_register_1[`CR1_QUAD_BIT];
  wire [31:0] cfg_next = {sh_r[7:0], sh_r[15:8], sh_r[23:16], sh_r[31:24]};
  wire        fifo_v;
  wire [7:0]  fifo_d;
  wire        fifo_take = (st_r == S_BOOT) & fifo_v & ~held_r;
  wire        fetch_push = array_valid & array_ready & (st_r == S_BOOT);
  wire        nv_done    = wip_r & ~program_fail &
                           (busy_cnt_r == 32'h00000000);
  assign status_register_1     = {1'b0, perr_r, eerr_r, 3'b000, wel_r, wip_r};
  assign boot_stream_config    = cfg_r;
  assign vol_learning_register = vol_r;
  assign corr_unit_addr        = {addr_r[31:4], 4'h0};
  assign array_addr            = fetch_r;
  // boot data path, stalls the array when full
  boot_fifo #(.WIDTH(8), .DEPTH(32), .AW(5)) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   (array_data),
    .in_valid  (array_valid & (st_r == S_BOOT)),
    .in_ready  (array_ready),
    .out_data  (fifo_d),
    .out_valid (fifo_v),
    .out_ready (fifo_take)
  );
  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= S_IDLE;
      op_r <= 8'h00;
      bit_r <= 6'd0;
      sh_r <= 32'h00000000;
      vol_r <= `NV_LEARN_RESET;
      wel_r <= 1'b0;
      wip_r <= 1'b0;
      eerr_r <= 1'b0;
      perr_r <= 1'b0;
      boot_arm_r <= 1'b1;
      busy_cfg_r <= 1'b0;
      busy_cnt_r <= 32'h00000000;
      addr_r <= 32'h00000000;
      lat_r <= 8'h00;
      rep_r <= 4'h0;
      held_r <= 1'b0;
      seen_r <= 1'b0;
      obyte_r <= 8'h00;
      obit_r <= 3'd0;
      reload_r <= 1'b0;
      fetch_r <= 32'h00000000;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      if (fetch_push)
        fetch_r <= fetch_r + 32'h00000001;
      // self-timed nonvolatile update
      // busy then done
      if (wip_r) begin
        if (busy_cnt_r == 32'h00000000) begin
          wip_r <= 1'b0;
          wel_r <= 1'b0;
          if (busy_cfg_r & erase_fail)
            eerr_r <= 1'b1;
          if (program_fail)
            perr_r <= 1'b1;
        end else
          busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      if (st_r == S_IDLE) begin
        vol_r <= nv_r;
        addr_r <= {cfg_r[`BOOT_ADDR_MSB:`BOOT_ADDR_LSB], 9'h000};
        fetch_r <= {cfg_r[`BOOT_ADDR_MSB:`BOOT_ADDR_LSB], 9'h000};
        st_r <= (boot_arm_r & cfg_r[`BOOT_ENABLE_BIT]) ? S_BOOT : S_CMD;
        lat_r <= cfg_r[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB];
        seen_r <= 1'b0;
        // head byte held until sent
        held_r <= 1'b1;
        obit_r <= 3'd0;
      end else if (cs_rise) begin
        io_oe <= 4'h0;
        bit_r <= 6'd0;
        reload_r <= 1'b0;
        if (st_r == S_BOOT && seen_r)
          boot_arm_r <= 1'b0;
        if (st_r != S_BOOT || seen_r)
          st_r <= S_CMD;
        if (st_r == S_CMD && bit_r == 6'd8 && op_r == `OP_WRITE_ENABLE
            && !wip_r)
          wel_r <= 1'b1;
        if (st_r == S_DATA && wel_r && !wip_r) begin
          if (op_r == `OP_BOOT_CFG_WR && bit_r == 6'd32) begin
            sh_r <= cfg_next;
            wip_r <= 1'b1;
            busy_cfg_r <= 1'b1;
            busy_cnt_r <= NV_CYC - 1;
          end
          if (op_r == `OP_NV_LEARN_PROG && bit_r == 6'd8) begin
            wip_r <= 1'b1;
            busy_cfg_r <= 1'b0;
            busy_cnt_r <= NV_CYC - 1;
          end
          if (op_r == `OP_VOL_LEARN_WR && bit_r == 6'd8) begin
            vol_r <= sh_r[7:0];
            wel_r <= 1'b0;
          end
        end
      end else begin
        case (st_r)
          S_CMD: begin
            if (sck_up_l && bit_r < 6'd8) begin
              op_r <= {op_r[6:0], si_s_r[2]};
              bit_r <= bit_r + 1'b1;
              if (bit_r == 6'd7) begin
                bit_r <= 6'd8;
                case ({op_r[6:0], si_s_r[2]})
                  `OP_CORR_STATUS_RD: begin
                    st_r <= S_ADDR;
                    bit_r <= 6'd0;
                  end
                  `OP_BOOT_CFG_RD: begin
                    sh_r <= {cfg_r[7:0], cfg_r[15:8], cfg_r[23:16],
                             cfg_r[31:24]};
                    st_r <= S_OUT;
                    bit_r <= 6'd0;
                  end
                  `OP_LEARN_PAT_RD: begin
                    sh_r <= {vol_r, 24'h000000};
                    st_r <= S_OUT;
                    bit_r <= 6'd0;
                  end
                  `OP_BOOT_CFG_WR, `OP_NV_LEARN_PROG,
                  `OP_VOL_LEARN_WR: begin
                    st_r <= S_DATA;
                    bit_r <= 6'd0;
                  end
                  default: st_r <= S_CMD;
                endcase
              end
            end
          end
          S_ADDR: begin
            // unit address, low nibble forced zero
            if (sck_up_l) begin
              addr_r <= {addr_r[30:0], si_s_r[2]};
              bit_r <= bit_r + 1'b1;
              if (bit_r == 6'd31) begin
                st_r <= S_WAIT;
                lat_r <= {4'h0, volatile_config_2};
                rep_r <= 4'h0;
                bit_r <= 6'd0;
              end
            end
          end
          S_WAIT: begin
            if (ddr_learn_enable && lat_r <= 8'd4 && lat_r != 8'd0) begin
              io_oe <= 4'hf;
              io_out <= {4{vol_r[{lat_r[1:0], 1'b0} - 3'd1]}};
            end
            if (lat_r == 8'd0) begin
              st_r <= S_OUT;
              sh_r <= {correction_unit_status, 24'h000000};
            end else if (sck_dn_l)
              lat_r <= lat_r - 1'b1;
          end
          S_OUT: begin
            if (sck_dn_l) begin
              io_oe <= 4'h2;
              io_out <= {2'b00, sh_r[31], 1'b0};
              sh_r <= {sh_r[30:0], sh_r[31]};
              bit_r <= bit_r + 1'b1;
              if (op_r == `OP_CORR_STATUS_RD && bit_r[2:0] == 3'd7) begin
                rep_r <= rep_r + 1'b1;
                reload_r <= 1'b1;
                if (rep_r == `CORR_UNIT_BYTES - 1)
                  addr_r <= addr_r + 32'h00000010;
              end
              if (op_r == `OP_LEARN_PAT_RD && bit_r[2:0] == 3'd7)
                sh_r <= {vol_r, 24'h000000};
            end else if (reload_r) begin
              // status taken once the unit address settles
              sh_r <= {correction_unit_status, 24'h000000};
              reload_r <= 1'b0;
            end
          end
          S_DATA: begin
            if (sck_up_l && bit_r < 6'd33) begin
              sh_r <= {sh_r[30:0], si_s_r[2]};
              bit_r <= bit_r + 1'b1;
            end
          end
          S_BOOT: begin
            if (sck_dn_l && lat_r != 8'd0)
              lat_r <= lat_r - 1'b1;
            else if (sck_dn_l && fifo_v) begin
              if (quad) begin
                io_oe <= 4'hf;
                io_out <= obit_r[2] ? fifo_d[3:0] : fifo_d[7:4];
                obit_r <= obit_r + 3'd4;
                held_r <= ~obit_r[2];
              end else begin
                io_oe <= 4'h2;
                io_out <= {2'b00, fifo_d[3'd7 - obit_r], 1'b0};
                obit_r <= obit_r + 1'b1;
                held_r <= (obit_r != 3'd7);
              end
              if ((quad && obit_r[2]) || (!quad && obit_r == 3'd7)) begin
                seen_r <= 1'b1;
                addr_r <= addr_r + 32'h00000001;
              end
            end else if (!held_r)
              held_r <= 1'b1;
          end
          default: st_r <= S_CMD;
        endcase
        if (fifo_take)
          held_r <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // nonvolatile storage, kept through resetn
  // ----------------------------------------
  always @(posedge mclk) begin
    if (nv_done & busy_cfg_r)
      cfg_r <= sh_r;
    if (nv_done & ~busy_cfg_r)
      nv_r <= sh_r[7:0];
  end
endmodule

// >>> verilog/boot_fifo.v
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module boot_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge mclk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule
